// ---- hw/xbr_route.sv ----
/*
 * Crossbar peripheral route enables: two special-function registers and the
 * priority decoder that turns them into a function code for every port pin.
 * Assumes the special-function register port, the skip mask, the global
 * crossbar enable and the serial wire mode all come from logic on I_CLK.
 */
`timescale 1ns/1ps

module xbr_route
    import xbr_pkg::*;
#(
    parameter int PIN_COUNT = 16
)
(
    input  wire logic                           I_CLK,
    input  wire logic                           I_RST,
    input  wire logic [7:0]                     I_SFR_ADDR,
    input  wire logic [7:0]                     I_SFR_PAGE,
    input  wire logic                           I_SFR_WR,
    input  wire logic                           I_SFR_RD,
    input  wire logic [7:0]                     I_SFR_WDATA,
    input  wire logic                           I_CROSSBAR_GLOBAL_ENABLE,
    input  wire logic [1:0]                     I_SERIAL_SLAVE_SELECT_MODE,
    input  wire logic [PIN_COUNT-1:0]           I_PIN_SKIP,
    output logic [7:0]                          O_SFR_RDATA,
    output logic [7:0]                          O_ROUTE_SELECT_A,
    output logic [7:0]                          O_ROUTE_SELECT_B,
    output logic [PIN_COUNT*XBR_FN_W-1:0]       O_PIN_FUNC,
    output logic                                O_PORT_OUTPUT_ALLOW
);
    import xbr_pkg::*;

    // Register state
    logic [7:0]                     route_a_q;      // First route register
    logic [7:0]                     route_a_d;
    logic [7:0]                     route_b_q;      // Second route register
    logic [7:0]                     route_b_d;
    logic [7:0]                     rdata_q;        // Read data held for the core
    logic [7:0]                     rdata_d;

    // Decoder state
    logic [PIN_COUNT*XBR_FN_W-1:0]  pin_func_q;     // Registered pin map
    logic [PIN_COUNT*XBR_FN_W-1:0]  pin_func_d;
    logic                           out_allow_q;    // Output drivers permitted
    logic                           out_allow_d;
    logic [XBR_FN_COUNT-1:0]        want;           // Functions asking for a pin

    // Address match on both address and page
    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] page,
                                     input logic [7:0] target);
        sfr_hit = (addr == target) && (page == XBR_ROUTE_PAGE);
    endfunction

    // Register next values; a write replaces all eight bits
    always_comb
    begin
        route_a_d = route_a_q;
        route_b_d = route_b_q;
        rdata_d   = rdata_q;
        if (I_SFR_WR && sfr_hit(I_SFR_ADDR, I_SFR_PAGE, XBR_ROUTE_A_ADDR))
        begin
            route_a_d = I_SFR_WDATA;
        end
        if (I_SFR_WR && sfr_hit(I_SFR_ADDR, I_SFR_PAGE, XBR_ROUTE_B_ADDR))
        begin
            // Reserved bit 0 is stored as written; software keeps it zero
            route_b_d = I_SFR_WDATA;
        end
        if (I_SFR_RD)
        begin
            if (sfr_hit(I_SFR_ADDR, I_SFR_PAGE, XBR_ROUTE_A_ADDR))
            begin
                rdata_d = route_a_q;
            end
            else if (sfr_hit(I_SFR_ADDR, I_SFR_PAGE, XBR_ROUTE_B_ADDR))
            begin
                rdata_d = route_b_q;
            end
            else
            begin
                // Unmapped reads answer a defined zero
                rdata_d = XBR_UNMAPPED_READ;
            end
        end
    end

    // Register flops; both route registers clear at reset
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            route_a_q <= XBR_ROUTE_A_RESET;
            route_b_q <= XBR_ROUTE_B_RESET;
            rdata_q   <= XBR_UNMAPPED_READ;
        end
        else
        begin
            route_a_q <= route_a_d;
            route_b_q <= route_b_d;
            rdata_q   <= rdata_d;
        end
    end

    // Which flexible functions request a pin, indexed by function code
    always_comb
    begin
        logic [2:0] mods;
        mods = route_b_q[XBR_B_MOD_HI:XBR_B_MOD_LO];
        // Reserved code is treated as all six modules rather than garbage
        if (mods > XBR_MOD_MAX)
        begin
            mods = XBR_MOD_MAX;
        end
        want = '0;
        // Serial peripheral: clock and data always, select per wire mode
        want[FN_SER_SCK]  = route_a_q[XBR_A_SERIAL];
        want[FN_SER_MISO] = route_a_q[XBR_A_SERIAL];
        want[FN_SER_MOSI] = route_a_q[XBR_A_SERIAL];
        want[FN_SER_NSS]  = route_a_q[XBR_A_SERIAL]
                          && (I_SERIAL_SLAVE_SELECT_MODE != XBR_SER_THREE_WIRE);
        // Two-wire bus requests both its pins; each is placed on its own
        want[FN_TW_SDA]      = route_a_q[XBR_A_TWOWIRE];
        want[FN_TW_SCL]      = route_a_q[XBR_A_TWOWIRE];
        want[FN_CMP_A_SYNC]  = route_a_q[XBR_A_CMP0_SYNC];
        want[FN_CMP_A_ASYNC] = route_a_q[XBR_A_CMP0_ASYNC];
        want[FN_CMP_B_SYNC]  = route_a_q[XBR_A_CMP1_SYNC];
        want[FN_CMP_B_ASYNC] = route_a_q[XBR_A_CMP1_ASYNC];
        want[FN_CLOCK_OUT]   = route_b_q[XBR_B_CLOCK_OUT];
        // Module pins 0 to N-1 for field value N
        for (int m = 0; m < 6; m++)
        begin
            want[int'(FN_MOD_PIN_0) + m] = (3'(m) < mods);
        end
        want[FN_EXT_IN]  = route_b_q[XBR_B_EXT_IN];
        want[FN_TIMER_A] = route_b_q[XBR_B_TIMER_A];
        want[FN_TIMER_B] = route_b_q[XBR_B_TIMER_B];
    end

    // Priority decoder: walk the pins in order, giving each free one the
    // highest-priority function still waiting. O(pins x functions) gates,
    // traded for a result that settles in one cycle.
    always_comb
    begin
        logic [XBR_FN_COUNT-1:0] taken;
        logic [XBR_FN_W-1:0]     fn;
        logic                    fixed;
        logic                    found;
        taken       = '0;
        fn          = FN_GPIO;
        fixed       = 1'b0;
        found       = 1'b0;
        pin_func_d  = '0;
        out_allow_d = I_CROSSBAR_GLOBAL_ENABLE;
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            fn    = FN_GPIO;
            fixed = 1'b0;
            // Async serial pair pinned for bootloading, skip mask ignored
            if (route_a_q[XBR_A_ASYNC_SER] && p == XBR_PIN_ASYNC_TX)
            begin
                fn    = FN_ASYNC_TX;
                fixed = 1'b1;
            end
            else if (route_a_q[XBR_A_ASYNC_SER] && p == XBR_PIN_ASYNC_RX)
            begin
                fn    = FN_ASYNC_RX;
                fixed = 1'b1;
            end
            else if (route_a_q[XBR_A_FIELDBUS] && p == XBR_PIN_FIELD_TX)
            begin
                fn    = FN_FIELD_TX;
                fixed = 1'b1;
            end
            else if (route_a_q[XBR_A_FIELDBUS] && p == XBR_PIN_FIELD_RX)
            begin
                fn    = FN_FIELD_RX;
                fixed = 1'b1;
            end
            // Skipped pins stay port I/O and are passed over
            if (!fixed && !I_PIN_SKIP[p])
            begin
                found = 1'b0;
                for (int f = XBR_FN_FIRST_FLEX; f < XBR_FN_COUNT; f++)
                begin
                    if (!found && want[f] && !taken[f])
                    begin
                        fn       = XBR_FN_W'(f);
                        taken[f] = 1'b1;
                        found    = 1'b1;
                    end
                end
                // Nothing left to place: pin continues as port I/O
            end
            // Disabled crossbar: every pin is plain port I/O in input mode
            if (!I_CROSSBAR_GLOBAL_ENABLE)
            begin
                fn = FN_GPIO;
            end
            pin_func_d[p*XBR_FN_W +: XBR_FN_W] = fn;
        end
    end

    // Decoder flops; pins come out of reset as plain inputs
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pin_func_q  <= '0;
            out_allow_q <= 1'b0;
        end
        else
        begin
            pin_func_q  <= pin_func_d;
            out_allow_q <= out_allow_d;
        end
    end

    // Outputs straight from flops
    assign O_SFR_RDATA         = rdata_q;
    assign O_ROUTE_SELECT_A    = route_a_q;
    assign O_ROUTE_SELECT_B    = route_b_q;
    assign O_PIN_FUNC          = pin_func_q;
    assign O_PORT_OUTPUT_ALLOW = out_allow_q;

endmodule

// ---- hw/xbr_pkg.sv ----
/*
 * Constants shared by the crossbar route-enable block: register addresses,
 * field positions, reset values and the codes that name each routed function.
 * Assumes an 8-bit special-function register port with address and page.
 */
// Behaviour
// - First route register at 0xE1, page 0x0F, clears.
// - Bit 7 routes comparator B unsynchronized output.
// - Bit 6 routes comparator B synchronized output.
// - Bit 5 routes comparator A unsynchronized output.
// - Bit 4 routes comparator A synchronized output.
// - Bit 3 routes both two-wire bus signals.
// - Bit 2 routes serial peripheral, three or four pins.
// - Bit 1 puts fieldbus TX/RX on P0.6/P0.7.
// - Bit 0 puts async serial TX/RX on P0.4/P0.5.
// - Second route register at 0xE2, page 0x0F, clears.
// - Bit 7 routes timer B external input.
// - Bit 6 routes timer A external input.
// - Bit 5 routes counter array external input.
// - Bits 4:2 route first N count module pins.
// - Bit 1 routes system clock output.
// - Crossbar disabled keeps pins plain inputs.
// - Fixed serial pairs always claim both pins; two-wire SDA can take the last free pin, leaving SCL unplaced.
// - Slave select pin follows serial wire mode.
// - Leftover non-skipped pins stay standard port I/O.
package xbr_pkg;

    // Register map (address and page)
    localparam logic [7:0] XBR_ROUTE_A_ADDR   = 8'hE1;
    localparam logic [7:0] XBR_ROUTE_B_ADDR   = 8'hE2;
    localparam logic [7:0] XBR_ROUTE_PAGE     = 8'h0F;
    localparam logic [7:0] XBR_ROUTE_A_RESET  = 8'h00;
    localparam logic [7:0] XBR_ROUTE_B_RESET  = 8'h00;
    localparam logic [7:0] XBR_UNMAPPED_READ  = 8'h00;

    // First route register fields
    localparam int XBR_A_CMP1_ASYNC = 7;
    localparam int XBR_A_CMP1_SYNC  = 6;
    localparam int XBR_A_CMP0_ASYNC = 5;
    localparam int XBR_A_CMP0_SYNC  = 4;
    localparam int XBR_A_TWOWIRE    = 3;
    localparam int XBR_A_SERIAL     = 2;
    localparam int XBR_A_FIELDBUS   = 1;
    localparam int XBR_A_ASYNC_SER  = 0;

    // Second route register fields
    localparam int XBR_B_TIMER_B    = 7;
    localparam int XBR_B_TIMER_A    = 6;
    localparam int XBR_B_EXT_IN     = 5;
    localparam int XBR_B_MOD_HI     = 4;
    localparam int XBR_B_MOD_LO     = 2;
    localparam int XBR_B_CLOCK_OUT  = 1;
    localparam logic [2:0] XBR_MOD_MAX = 3'h6;

    // Fixed pin positions of the paired serial links
    localparam int XBR_PIN_ASYNC_TX = 4;
    localparam int XBR_PIN_ASYNC_RX = 5;
    localparam int XBR_PIN_FIELD_TX = 6;
    localparam int XBR_PIN_FIELD_RX = 7;

    // Function codes shown per pin; order of the flexible ones is priority
    localparam int XBR_FN_W = 5;
    localparam logic [4:0] FN_GPIO        = 5'h00;
    localparam logic [4:0] FN_ASYNC_TX    = 5'h01;
    localparam logic [4:0] FN_ASYNC_RX    = 5'h02;
    localparam logic [4:0] FN_FIELD_TX    = 5'h03;
    localparam logic [4:0] FN_FIELD_RX    = 5'h04;
    localparam logic [4:0] FN_SER_SCK     = 5'h05;
    localparam logic [4:0] FN_SER_MISO    = 5'h06;
    localparam logic [4:0] FN_SER_MOSI    = 5'h07;
    localparam logic [4:0] FN_SER_NSS     = 5'h08;
    localparam logic [4:0] FN_TW_SDA      = 5'h09;
    localparam logic [4:0] FN_TW_SCL      = 5'h0A;
    localparam logic [4:0] FN_CMP_A_SYNC  = 5'h0B;
    localparam logic [4:0] FN_CMP_A_ASYNC = 5'h0C;
    localparam logic [4:0] FN_CMP_B_SYNC  = 5'h0D;
    localparam logic [4:0] FN_CMP_B_ASYNC = 5'h0E;
    localparam logic [4:0] FN_CLOCK_OUT   = 5'h0F;
    localparam logic [4:0] FN_MOD_PIN_0   = 5'h10;
    localparam logic [4:0] FN_EXT_IN      = 5'h16;
    localparam logic [4:0] FN_TIMER_A     = 5'h17;
    localparam logic [4:0] FN_TIMER_B     = 5'h18;
    localparam int XBR_FN_FIRST_FLEX = 5;
    localparam int XBR_FN_COUNT      = 25;

    // Wire-mode code that means three-wire (no slave select pin)
    localparam logic [1:0] XBR_SER_THREE_WIRE = 2'h0;

endpackage

// ---- verification/xbr_route_assertions.sv ----
/* Port checker for the crossbar route block.
   Assumes a bind onto xbr_route, one clock I_CLK, reset I_RST high. */
`timescale 1ns/1ps
module xbr_route_assertions
    import xbr_pkg::*;
#(
    parameter int PIN_COUNT = 16
)
(
    input wire logic                         I_CLK,
    input wire logic                         I_RST,
    input wire logic [7:0]                   I_SFR_ADDR,
    input wire logic [7:0]                   I_SFR_PAGE,
    input wire logic                         I_SFR_WR,
    input wire logic                         I_SFR_RD,
    input wire logic [7:0]                   I_SFR_WDATA,
    input wire logic                         I_CROSSBAR_GLOBAL_ENABLE,
    input wire logic [1:0]                   I_SERIAL_SLAVE_SELECT_MODE,
    input wire logic [PIN_COUNT-1:0]         I_PIN_SKIP,
    input wire logic [7:0]                   O_SFR_RDATA,
    input wire logic [7:0]                   O_ROUTE_SELECT_A,
    input wire logic [7:0]                   O_ROUTE_SELECT_B,
    input wire logic [PIN_COUNT*XBR_FN_W-1:0] O_PIN_FUNC,
    input wire logic                         O_PORT_OUTPUT_ALLOW
);
    // Register decode; the page must match as well as the address
    logic hit_a;
    logic hit_b;
    logic en;
    assign hit_a = (I_SFR_ADDR == XBR_ROUTE_A_ADDR) && (I_SFR_PAGE == XBR_ROUTE_PAGE);
    assign hit_b = (I_SFR_ADDR == XBR_ROUTE_B_ADDR) && (I_SFR_PAGE == XBR_ROUTE_PAGE);
    assign en = I_CROSSBAR_GLOBAL_ENABLE;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    write_a_a: assert property (I_SFR_WR && hit_a |=>
        O_ROUTE_SELECT_A == $past(I_SFR_WDATA))
        else $error("route A write lost");
    hold_a_a: assert property (!(I_SFR_WR && hit_a) |=> $stable(O_ROUTE_SELECT_A))
        else $error("route A changed without write");
    write_b_a: assert property (I_SFR_WR && hit_b |=>
        O_ROUTE_SELECT_B == $past(I_SFR_WDATA))
        else $error("route B write lost");
    read_a_a: assert property (I_SFR_RD && hit_a |=>
        O_SFR_RDATA == $past(O_ROUTE_SELECT_A))
        else $error("route A read wrong");
    read_miss_a: assert property (I_SFR_RD && !hit_a && !hit_b |=>
        O_SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    off_gpio_a: assert property (!en |=> O_PIN_FUNC == '0)
        else $error("pins routed while crossbar off");
    allow_follow_a: assert property (1'b1 |=> O_PORT_OUTPUT_ALLOW == $past(en))
        else $error("output allow does not follow enable");
    uart_pins_a: assert property (en && O_ROUTE_SELECT_A[XBR_A_ASYNC_SER] |=>
        O_PIN_FUNC[XBR_PIN_ASYNC_TX*XBR_FN_W +: 2*XBR_FN_W] == {FN_ASYNC_RX, FN_ASYNC_TX})
        else $error("async serial not on its fixed pins");
    field_pins_a: assert property (en && O_ROUTE_SELECT_A[XBR_A_FIELDBUS] |=>
        O_PIN_FUNC[XBR_PIN_FIELD_TX*XBR_FN_W +: 2*XBR_FN_W] == {FN_FIELD_RX, FN_FIELD_TX})
        else $error("fieldbus not on its fixed pins");
    sck_first_a: assert property (en && O_ROUTE_SELECT_A[XBR_A_SERIAL]
        && !I_PIN_SKIP[0] |=> O_PIN_FUNC[XBR_FN_W-1:0] == FN_SER_SCK)
        else $error("serial clock not on first free pin");
endmodule

// ---- verification/xbr_periph_side.sv ----
/* Peripheral-side model: each peripheral learns whether a pin carries it.
   Assumes the pin code layout of xbr_pkg. */
`timescale 1ns/1ps
module xbr_periph_side
    import xbr_pkg::*;
#(
    parameter int PIN_COUNT = 16
)
(
    input  wire logic [PIN_COUNT*XBR_FN_W-1:0] i_pin_func,
    output logic [XBR_FN_COUNT-1:0]            o_placed
);
    // A function is live when any pin shows its code
    always_comb
    begin
        o_placed = '0;
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            o_placed[i_pin_func[p*XBR_FN_W +: XBR_FN_W]] = 1'b1;
        end
    end
endmodule

// ---- verification/xbr_tb.sv ----
/* Register-call testbench for the crossbar route block.
   Assumes xbr_route with 16 pins; inputs move on the falling edge. */
`timescale 1ns/1ps
module testbench;
    import xbr_pkg::*;
    localparam int PC = 16;
    logic clk, rst, wr, rd, en;
    logic [7:0] addr, page, wdata, rdata, ra, rb;
    logic [1:0] mode;
    logic [PC-1:0] skip;
    logic [PC*XBR_FN_W-1:0] pfunc;
    logic allow;
    logic [XBR_FN_COUNT-1:0] placed;
    int fail_count = 0;
    int cmp_count = 0;
    xbr_route #(.PIN_COUNT(PC)) dut (.I_CLK(clk), .I_RST(rst), .I_SFR_ADDR(addr),
        .I_SFR_PAGE(page), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
        .I_CROSSBAR_GLOBAL_ENABLE(en), .I_SERIAL_SLAVE_SELECT_MODE(mode), .I_PIN_SKIP(skip),
        .O_SFR_RDATA(rdata), .O_ROUTE_SELECT_A(ra), .O_ROUTE_SELECT_B(rb),
        .O_PIN_FUNC(pfunc), .O_PORT_OUTPUT_ALLOW(allow));
    xbr_periph_side #(.PIN_COUNT(PC)) u_side (.i_pin_func(pfunc), .o_placed(placed));
    // Free-running 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // One-cycle strobes, entered and left at a falling edge; a quiet cycle
    // follows so a back-to-back call never lowers and raises in one step
    task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] pg, input logic [7:0] d);
        addr = ad;
        page = pg;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic sfr_rd(input logic [7:0] ad, input logic [7:0] pg, input logic [7:0] e);
        addr = ad;
        page = pg;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("rdata", 80'(e), 80'(rdata));
        @(negedge clk);
    endtask
    // Own priority decoder: fixed pairs first, then flexible codes in order
    function automatic logic [79:0] exp_map(logic [7:0] a, logic [7:0] b, logic [15:0] sk,
        logic [1:0] md, logic e);
        logic [XBR_FN_COUNT-1:0] w;
        logic [79:0] m;
        int f;
        w = '0;
        m = '0;
        f = XBR_FN_FIRST_FLEX;
        w[8:5] = {a[2] && (md != XBR_SER_THREE_WIRE), {3{a[2]}}};
        w[10:9] = {2{a[3]}};
        w[14:11] = a[7:4];
        w[15] = b[1];
        for (int i = 0; i < 6; i++) w[16+i] = (i < int'(b[4:2]));
        w[24:22] = b[7:5];
        if (!e) return '0;
        if (a[0]) m[20 +: 10] = {FN_ASYNC_RX, FN_ASYNC_TX};
        if (a[1]) m[30 +: 10] = {FN_FIELD_RX, FN_FIELD_TX};
        for (int p = 0; p < PC; p++)
        begin
            if (((p == 4 || p == 5) && a[0]) || ((p == 6 || p == 7) && a[1]) || sk[p]) continue;
            while (f < XBR_FN_COUNT && !w[f]) f++;
            if (f < XBR_FN_COUNT) m[p*5 +: 5] = 5'(f);
            f++;
        end
        return m;
    endfunction
    // Load both routes and the port setup, then compare the settled map
    task automatic run_map(input logic [7:0] a, input logic [7:0] b, input logic [15:0] sk,
        input logic [1:0] md, input logic e);
        sfr_wr(XBR_ROUTE_A_ADDR, XBR_ROUTE_PAGE, a);
        sfr_wr(XBR_ROUTE_B_ADDR, XBR_ROUTE_PAGE, b);
        skip = sk;
        mode = md;
        en = e;
        repeat (2) @(negedge clk);
        chk("pin map", exp_map(a, b, sk, md, e), pfunc);
        chk("allow", 80'(e), 80'(allow));
        chk("pairs", 80'({placed[1], placed[3], placed[9]}),
            80'({placed[2], placed[4], placed[10]}));
    endtask
    // Main sequence
    initial
    begin
        {rst, wr, rd, en, addr, page, wdata, mode, skip} = '0;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk("reset routes", 80'({XBR_ROUTE_A_RESET, XBR_ROUTE_B_RESET}), 80'({ra, rb}));
        sfr_rd(XBR_ROUTE_B_ADDR, XBR_ROUTE_PAGE, XBR_ROUTE_B_RESET);
        $display("test reset done");
        sfr_wr(XBR_ROUTE_A_ADDR, XBR_ROUTE_PAGE, 8'hA5);
        sfr_wr(XBR_ROUTE_B_ADDR, XBR_ROUTE_PAGE, 8'h5A);
        sfr_wr(XBR_ROUTE_A_ADDR, 8'h00, 8'h3C);
        sfr_rd(XBR_ROUTE_A_ADDR, XBR_ROUTE_PAGE, 8'hA5);
        sfr_rd(XBR_ROUTE_B_ADDR, XBR_ROUTE_PAGE, 8'h5A);
        sfr_rd(8'hE3, XBR_ROUTE_PAGE, XBR_UNMAPPED_READ);
        $display("test registers done");
        run_map(8'h06, 8'h0C, 16'h0026, 2'h1, 1'b1);
        run_map(8'h04, 8'h00, 16'h0000, 2'h0, 1'b1);
        run_map(8'hFF, 8'hFA, 16'h00F1, 2'h3, 1'b1);
        run_map(8'hFF, 8'hFA, 16'h0000, 2'h1, 1'b0);
        $display("test examples done");
        for (int i = 0; i < 8; i++)
        begin
            run_map(8'(1 << i), 8'h00, 16'h0000, 2'h1, 1'b1);
            if (i > 0)
                run_map(8'h00, 8'(1 << i), 16'h0000, 2'h1, 1'b1);
        end
        for (int n = 0; n < 7; n++) run_map(8'h00, 8'(n << 2), 16'h0003, 2'h1, 1'b1);
        $display("test fields done");
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk("rerun reset", 80'h0, 80'({ra, rb, pfunc}));
        $display("test second reset done");
        final_report();
    end
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
endmodule
bind xbr_route xbr_route_assertions #(.PIN_COUNT(PIN_COUNT)) u_chk (.I_CLK(I_CLK),
    .I_RST(I_RST), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_PAGE(I_SFR_PAGE), .I_SFR_WR(I_SFR_WR),
    .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA), .I_PIN_SKIP(I_PIN_SKIP),
    .I_CROSSBAR_GLOBAL_ENABLE(I_CROSSBAR_GLOBAL_ENABLE), .O_PIN_FUNC(O_PIN_FUNC),
    .I_SERIAL_SLAVE_SELECT_MODE(I_SERIAL_SLAVE_SELECT_MODE), .O_SFR_RDATA(O_SFR_RDATA),
    .O_ROUTE_SELECT_A(O_ROUTE_SELECT_A), .O_ROUTE_SELECT_B(O_ROUTE_SELECT_B),
    .O_PORT_OUTPUT_ALLOW(O_PORT_OUTPUT_ALLOW));
